// [verilog/fss_summary.sv]
`timescale 1ns/1ns
`default_nettype none
// Operation
// - bit 7: OR of enabled communication errors and the unmasked SPI clock count error
// - bit 5: OR of channel demag faults
// - bit 4: OR of short-to-supply faults
// - bit 2: OR of open-wire-off faults
// - bit 1: OR of current-limit flags
// - bit 0: OR of thermal overload flags
// - global thermal shutdown also drives bit 0
// - demag faults always latched, never masked
// - limit/overload flags follow fault latch enable
module fss_summary
    import fss_pkg::*;
#(
    parameter int CHANNELS = fss_pkg::FSS_CHANNELS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register read port
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data,
    // communication error sources and enables
    input wire logic spi_wdog_err,
    input wire logic spi_wdog_en,
    input wire logic sync_wdog_err,
    input wire logic sync_wdog_en,
    input wire logic spi_crc_err,
    input wire logic spi_crc_en,
    input wire logic spi_clk_count_err,
    // supply
    input wire logic supply_error_src,
    input wire logic supply_fault_disable,
    // per-channel conditions
    input wire logic [CHANNELS-1:0] chan_demag_cond,
    input wire logic [CHANNELS-1:0] chan_short_supply,
    input wire logic [CHANNELS-1:0] chan_above_supply,
    input wire logic [CHANNELS-1:0] chan_open_wire,
    input wire logic [CHANNELS-1:0] chan_current_limit_cond,
    input wire logic [CHANNELS-1:0] chan_thermal_overload_cond,
    input wire logic global_thermal_shutdown,
    input wire logic fault_latch_enable,
    input wire logic demag_clear,
    // summary and flags
    output logic [7:0] fault_summary,
    output logic [CHANNELS-1:0] chan_demag_fault,
    output logic [CHANNELS-1:0] chan_current_limit,
    output logic [CHANNELS-1:0] chan_thermal_overload
);
    import fss_pkg::*;
    // ==========================================
    // decode
    wire logic rd_overload = rd_en && (rd_addr == FSS_ADDR_OVERLOAD);
    wire logic rd_summary = rd_en && (rd_addr == FSS_ADDR_SUMMARY);
    // ==========================================
    // per-channel flags
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            fss_chan_flag u_demag (
                .clk(clk),
                .rstn(rstn),
                .latch_en(1'b1),
                .hold_always(1'b1),
                .clear_req(demag_clear),
                .cond(chan_demag_cond[g]),
                .flag(chan_demag_fault[g])
            );
            fss_chan_flag u_clim (
                .clk(clk),
                .rstn(rstn),
                .latch_en(fault_latch_enable),
                .hold_always(1'b0),
                .clear_req(rd_overload),
                .cond(chan_current_limit_cond[g]),
                .flag(chan_current_limit[g])
            );
            fss_chan_flag u_ovld (
                .clk(clk),
                .rstn(rstn),
                .latch_en(fault_latch_enable),
                .hold_always(1'b0),
                .clear_req(rd_overload),
                .cond(chan_thermal_overload_cond[g]),
                .flag(chan_thermal_overload[g])
            );
        end
    endgenerate
    // ==========================================
    // summary bits, one cycle after their sources
    wire logic comm_error_any = (spi_wdog_err & spi_wdog_en) | (sync_wdog_err & sync_wdog_en)
        | (spi_crc_err & spi_crc_en) | spi_clk_count_err;
    wire logic supply_error_any = supply_error_src & ~supply_fault_disable;
    wire logic demag_fault_any = |chan_demag_fault;
    wire logic short_to_supply_any = |chan_short_supply;
    wire logic above_supply_any = |chan_above_supply;
    wire logic open_wire_off_any = |chan_open_wire;
    wire logic current_limit_any = |chan_current_limit;
    wire logic thermal_overload_any = (|chan_thermal_overload) | global_thermal_shutdown;
    logic [7:0] next_summary;
    assign next_summary = {comm_error_any, supply_error_any, demag_fault_any, short_to_supply_any,
        above_supply_any, open_wire_off_any, current_limit_any, thermal_overload_any};
    // no write path exists: the summary is read-only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_summary <= FSS_SUMMARY_RESET;
        end else begin
            fault_summary <= next_summary;
        end
    end
    // ==========================================
    // read data, registered
    // unmapped addresses keep the old word, so a stray read cannot hide a fault
    logic [7:0] next_rd_data;
    wire logic [7:0] overload_word = {chan_current_limit, chan_thermal_overload};
    assign next_rd_data = rd_summary ? fault_summary :
        rd_overload ? overload_word : rd_data;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end
    // ==========================================
    // checks
    a_comm_bit: assert property (@(posedge clk) disable iff (!rstn)
        (spi_crc_err && spi_crc_en) |=> fault_summary[FSS_BIT_COMM])
        else $error("comm bit missed crc error");
    a_demag_bit: assert property (@(posedge clk) disable iff (!rstn)
        $rose(|chan_demag_fault) |=> fault_summary[FSS_BIT_DEMAG])
        else $error("demag bit missed");
    a_short_bit: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> fault_summary[FSS_BIT_SHORT] == $past(|chan_short_supply))
        else $error("short bit wrong");
    a_open_bit: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> fault_summary[FSS_BIT_OPEN] == $past(|chan_open_wire))
        else $error("open wire bit wrong");
    a_clim_bit: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> fault_summary[FSS_BIT_CLIM] == $past(|chan_current_limit))
        else $error("current limit bit wrong");
    a_ovld_bit: assert property (@(posedge clk) disable iff (!rstn)
        global_thermal_shutdown |=> fault_summary[FSS_BIT_OVLD])
        else $error("shutdown did not raise overload bit");
    a_demag_held: assert property (@(posedge clk) disable iff (!rstn)
        (chan_demag_fault[0] && !demag_clear) |=> chan_demag_fault[0])
        else $error("demag fault dropped without clear");
    a_rt_track: assert property (@(posedge clk) disable iff (!rstn)
        !fault_latch_enable |=> chan_current_limit == $past(chan_current_limit_cond))
        else $error("current limit not real time");
    a_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
        (fault_latch_enable && chan_thermal_overload[0] && !rd_overload) |=> chan_thermal_overload[0])
        else $error("latched overload lost");
    a_above_bit: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> fault_summary[FSS_BIT_ABOVE] == $past(|chan_above_supply))
        else $error("above supply bit wrong");
    // ==========================================
    // summary source checks
    a_comm_wdog: assert property (@(posedge clk) disable iff (!rstn)
        (spi_wdog_err && spi_wdog_en) |=> fault_summary[FSS_BIT_COMM])
        else $error("comm bit missed spi watchdog");
    a_comm_sync: assert property (@(posedge clk) disable iff (!rstn)
        (sync_wdog_err && sync_wdog_en) |=> fault_summary[FSS_BIT_COMM])
        else $error("comm bit missed sync watchdog");
    a_comm_count: assert property (@(posedge clk) disable iff (!rstn)
        spi_clk_count_err |=> fault_summary[FSS_BIT_COMM])
        else $error("comm bit missed clock count");
    a_comm_quiet: assert property (@(posedge clk) disable iff (!rstn)
        (!(spi_wdog_err && spi_wdog_en) && !(sync_wdog_err && sync_wdog_en) && !(spi_crc_err && spi_crc_en)
        && !spi_clk_count_err) |=> !fault_summary[FSS_BIT_COMM])
        else $error("comm bit set with no enabled error");
    a_supply_bit: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> fault_summary[FSS_BIT_SUPPLY] == $past(supply_error_src && !supply_fault_disable))
        else $error("supply bit wrong");
    a_demag_any: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> fault_summary[FSS_BIT_DEMAG] == $past(|chan_demag_fault))
        else $error("demag bit not the channel or");
    a_short_set: assert property (@(posedge clk) disable iff (!rstn)
        (|chan_short_supply) |=> fault_summary[FSS_BIT_SHORT])
        else $error("short bit missed a channel");
    a_ovld_any: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> fault_summary[FSS_BIT_OVLD] == $past((|chan_thermal_overload) || global_thermal_shutdown))
        else $error("overload bit wrong");
    a_ovld_chan: assert property (@(posedge clk) disable iff (!rstn)
        (|chan_thermal_overload) |=> fault_summary[FSS_BIT_OVLD])
        else $error("overload bit missed a channel");
    // ==========================================
    // per-channel flag checks
    a_demag_set: assert property (@(posedge clk) disable iff (!rstn)
        chan_demag_cond[0] |=> chan_demag_fault[0])
        else $error("demag fault not raised");
    a_ovl_rt: assert property (@(posedge clk) disable iff (!rstn)
        !fault_latch_enable |=> chan_thermal_overload == $past(chan_thermal_overload_cond))
        else $error("overload not real time");
    a_clim_hold: assert property (@(posedge clk) disable iff (!rstn)
        (fault_latch_enable && chan_current_limit[0] && !rd_overload) |=> chan_current_limit[0])
        else $error("latched current limit lost");
    a_clim_set: assert property (@(posedge clk) disable iff (!rstn)
        (fault_latch_enable && chan_current_limit_cond[0]) |=> chan_current_limit[0])
        else $error("latched current limit not raised");
    a_latch_set: assert property (@(posedge clk) disable iff (!rstn)
        (fault_latch_enable && chan_thermal_overload_cond[0]) |=> chan_thermal_overload[0])
        else $error("latched overload not raised");
    a_read_clear: assert property (@(posedge clk) disable iff (!rstn)
        (fault_latch_enable && rd_overload && !chan_thermal_overload_cond[0]) |=> !chan_thermal_overload[0])
        else $error("overload not cleared by read");
    // ==========================================
    // read port checks
    a_rd_summary: assert property (@(posedge clk) disable iff (!rstn)
        rd_summary |=> rd_data == $past(fault_summary))
        else $error("summary read data wrong");
    a_rd_overload: assert property (@(posedge clk) disable iff (!rstn)
        rd_overload |=> rd_data == $past({chan_current_limit, chan_thermal_overload}))
        else $error("overload read data wrong");
    a_rd_hold: assert property (@(posedge clk) disable iff (!rstn)
        (!rd_summary && !rd_overload) |=> $stable(rd_data))
        else $error("read data moved without a decoded read");
endmodule
`default_nettype wire

// [verilog/fss_pkg.sv]
package fss_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] FSS_ADDR_SUMMARY = 8'h03;
    localparam logic [7:0] FSS_ADDR_OVERLOAD = 8'h04;
    localparam int FSS_CHANNELS = 4;
    // ==========================================
    // summary bit positions
    localparam int FSS_BIT_COMM = 7;
    localparam int FSS_BIT_SUPPLY = 6;
    localparam int FSS_BIT_DEMAG = 5;
    localparam int FSS_BIT_SHORT = 4;
    localparam int FSS_BIT_ABOVE = 3;
    localparam int FSS_BIT_OPEN = 2;
    localparam int FSS_BIT_CLIM = 1;
    localparam int FSS_BIT_OVLD = 0;
    // ==========================================
    // reset values
    localparam logic [7:0] FSS_SUMMARY_RESET = 8'h40;
    localparam logic [3:0] FSS_CHAN_RESET = 4'h0;
endpackage

// [verilog/fss_chan_flag.sv]
`timescale 1ns/1ns
`default_nettype none
// one per-channel fault flag: real time or latched until read and condition gone
module fss_chan_flag (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic latch_en,
    input wire logic hold_always,
    input wire logic clear_req,
    // condition and flag
    input wire logic cond,
    output logic flag
);
    logic next_flag;
    wire logic latching = latch_en | hold_always;
    // set wins over the read clear, so an event at the clear is kept
    assign next_flag = latching ? (cond | (flag & ~clear_req)) : cond;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule
`default_nettype wire

// [tb/fss_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ====
// host side: one-cycle read strobes
module fss_host_model (
    // clock
    input wire logic clk,
    // read port
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial begin
        rd_en = 1'b0;
        rd_addr = 8'hff;
    end
    // idle address is inverted so nothing leans on a stale value
    task automatic read(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        #1;
        dat = rd_data;
    endtask
endmodule
`default_nettype wire

// [tb/fault_summary_status_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, v); end end
// ====
// bench top
module fault_summary_status_test;
    import fss_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [35:0] s = '0;
    logic rd_en;
    logic [7:0] rd_addr, rd_data, fsum, r;
    logic [3:0] dm, cl, ov;
    int checks = 0;
    int miscompares = 0;
    always #4 clk = ~clk;
    fss_summary fss_summary_i (.clk(clk), .rstn(rstn), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .spi_wdog_err(s[24]), .spi_wdog_en(s[25]), .sync_wdog_err(s[26]), .sync_wdog_en(s[27]),
        .spi_crc_err(s[28]), .spi_crc_en(s[29]), .spi_clk_count_err(s[30]), .supply_error_src(s[31]),
        .supply_fault_disable(s[32]), .chan_demag_cond(s[3:0]), .chan_short_supply(s[7:4]),
        .chan_above_supply(s[11:8]), .chan_open_wire(s[15:12]), .chan_current_limit_cond(s[19:16]),
        .chan_thermal_overload_cond(s[23:20]), .global_thermal_shutdown(s[33]), .fault_latch_enable(s[34]),
        .demag_clear(s[35]), .fault_summary(fsum), .chan_demag_fault(dm), .chan_current_limit(cl),
        .chan_thermal_overload(ov));
    fss_host_model fss_host_model_i (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic d(input logic [35:0] v);
        @(posedge clk);
        s <= v;
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ====
    // watchdog: the sequence has only fixed waits, this cuts any hang
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
    // ====
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #1 `CHK("reset", 8'h40, fsum)
        @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            for (int c = 0; c < 4; c++) begin
                d(36'h1 << (4 * k + c));
                w(3);
                `CHK("chan", 8'h20 >> k, fsum)
                d('0);
                w(3);
                `CHK("hold", (k == 0) ? 8'h20 : 8'h00, fsum)
                `CHK("dm_hold", (k == 0) ? (4'h1 << c) : 4'h0, dm)
                d(36'h1 << 35);
                d('0);
                w(3);
                `CHK("clear", 8'h00, fsum)
            end
        end
        for (int j = 0; j < 3; j++) begin
            d(36'h1 << (24 + 2 * j));
            w(3);
            `CHK("comm_off", 8'h00, fsum)
            d(36'h3 << (24 + 2 * j));
            w(3);
            `CHK("comm_on", 8'h80, fsum)
        end
        d(36'h1 << 30);
        w(3);
        `CHK("clk_count", 8'h80, fsum)
        d(36'h1 << 31);
        w(3);
        `CHK("supply", 8'h40, fsum)
        d(36'h3 << 31);
        w(3);
        `CHK("supply_off", 8'h00, fsum)
        d(36'h1 << 33);
        w(3);
        `CHK("shutdown", 8'h01, fsum)
        fss_host_model_i.read(FSS_ADDR_SUMMARY, r);
        `CHK("read_sum", 8'h01, r)
        fss_host_model_i.read(8'h55, r);
        `CHK("unmapped", 8'h01, r)
        // latched flags outlive their condition until read
        d((36'h1 << 34) | (36'h1 << 16) | (36'h1 << 20));
        d(36'h1 << 34);
        w(3);
        `CHK("latched", 8'h11, {cl, ov})
        `CHK("lat_sum", 8'h03, fsum)
        fss_host_model_i.read(FSS_ADDR_OVERLOAD, r);
        `CHK("read_ovl", 8'h11, r)
        w(3);
        `CHK("rd_clear", 8'h00, {cl, ov})
        `CHK("rd_sum", 8'h00, fsum)
        complete_run();
    end
endmodule
`default_nettype wire
